/* File: common/osgp_consts.svh */
// Register offsets, field positions, reset values and bus codes of the shared-pin GPIO block
`ifndef OSGP_CONSTS_SVH
`define OSGP_CONSTS_SVH

`define OSGP_OFF_F_DATA 8'h00
`define OSGP_OFF_F_DIR 8'h04
`define OSGP_OFF_G_DATA 8'h08
`define OSGP_OFF_G_DIR 8'h0C
`define OSGP_OFF_G_PULL 8'h10
`define OSGP_OFF_SYS_CFG 8'h14
`define OSGP_OFF_STBY_CTRL 8'h18
`define OSGP_OFF_ACCESS 8'h1C

`define OSGP_SYS_RSTSEL_BIT 0
`define OSGP_SYS_OD_LSB 4
`define OSGP_STBY_FLOAT_BIT 0
`define OSGP_STBY_STOP_BIT 1
`define OSGP_STBY_WATCH_BIT 2
`define OSGP_ACC_RMW_BIT 0

`define OSGP_RST_F_DATA 3'h0
`define OSGP_RST_F_DIR 3'h0
`define OSGP_RST_F_OD 3'h0
`define OSGP_RST_G_DATA 2'h0
`define OSGP_RST_G_DIR 2'h0
`define OSGP_RST_G_PULL 2'h0

`define OSGP_RESP_OKAY 2'b00
`define OSGP_RESP_SLVERR 2'b10

`endif

/* File: common/osgp_pkg.sv */
// Types of the shared-pin GPIO block
package osgp_pkg;

    typedef enum logic [2:0] {
        OSGP_RUN = 3'b001,
        OSGP_STOP = 3'b010,
        OSGP_WATCH = 3'b100
    } osgp_mode_t;

endpackage

/* File: verilog/osgp_pin_cell.sv */
// One general-purpose pin: output register, float and hold in standby, input gate
`timescale 1ns/100ps
`default_nettype none

module osgp_pin_cell (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic dir,
    input wire logic latch,
    input wire logic open_drain,
    input wire logic avail,
    input wire logic hold,
    input wire logic float_en,
    input wire logic pull_bit,
    // Pin
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe,
    output logic pull_on,
    output logic in_level
);

    // Outputs freeze while held unless floated, so a standby keeps the old level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_oe <= 1'b0;
            pin_o <= 1'b0;
        end else if (float_en) begin
            pin_oe <= 1'b0;
        end else if (!hold) begin
            pin_oe <= avail & dir & ~(open_drain & latch);
            pin_o <= latch & ~open_drain;
        end
    end

    // Pull-up never fights a low drive
    assign pull_on = pull_bit & ~(pin_oe & ~pin_o);
    // Floated input forced low to avoid leakage through an open gate
    assign in_level = pin_i & avail & ~float_en;

endmodule

`default_nettype wire

/* File: verilog/osgp_axil_slave.sv */
// AXI4-Lite slave front end: handshakes, one-word write and read strobes
`timescale 1ns/100ps
`default_nettype none
`include "osgp_consts.svh"

module osgp_axil_slave (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Register side
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    output logic wr_lane0,
    input wire logic wr_ok,
    output logic rd_en,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic rd_ok
);

    logic aw_held;
    logic w_held;

    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;
    assign wr_en = aw_held & w_held;
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_en = s_axi_arvalid & s_axi_arready;
    assign rd_addr = s_axi_araddr;

    // Address and data may arrive in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
            wr_lane0 <= 1'b0;
        end else if (wr_en) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                wr_data <= s_axi_wdata[7:0];
                wr_lane0 <= s_axi_wstrb[0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `OSGP_RESP_OKAY;
        end else if (wr_en) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `OSGP_RESP_OKAY : `OSGP_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `OSGP_RESP_OKAY;
        end else if (rd_en) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_data};
            s_axi_rresp <= rd_ok ? `OSGP_RESP_OKAY : `OSGP_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* File: verilog/osgp_top.sv */
// Shared oscillator/reset pin GPIO ports F and G behind an AXI4-Lite register file
//
// Contract
// RULE1 - Port F direction one drives the pin with its latch bit.
// RULE2 - Port F direction zero makes the pin an input, driver off.
// RULE3 - Port F data writes always load the latch; only outputs show it.
// RULE4 - Port F input read gives pin level; read-modify-write read gives latch.
// RULE5 - Port F output read gives the latch value.
// RULE6 - Reset clears all port F direction bits, pins become inputs.
// RULE7 - Float bit set in stop or watch: port F floats, input forced low.
// RULE8 - Float bit clear in stop or watch: pin states and levels held.
// RULE9 - Open-drain port F output with latch one stays high impedance.
// RULE10 - External reset selected: port F pin 2 is reset input, no port.
// RULE11 - Port F uses bits 0 to 2; upper five bits absent.
// RULE12 - Port G uses bits 1 and 2; others absent.
// RULE13 - Port G direction one drives the pin with its latch bit.
// RULE14 - Port G direction zero makes the pin an input, driver off.
// RULE15 - Port G data writes always load the latch; only outputs show it.
// RULE16 - Port G input read gives pin level; read-modify-write read gives latch.
// RULE17 - Port G output read gives the latch value.
// RULE18 - Reset clears all port G direction bits.
// RULE19 - Float bit set in stop or watch: port G floats, input forced low.
// RULE20 - Port G pull-up bit one connects the pull-up.
// RULE21 - Port G pin driving low disconnects its pull-up.
// RULE22 - Software disables shared peripheral outputs before using a pin as port.
// RULE23 - Absent register bits ignore writes and read zero.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "osgp_consts.svh"

module osgp_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Port F pins
    input wire logic [2:0] port_f_pin_i,
    output logic [2:0] port_f_pin_o,
    output logic [2:0] port_f_pin_oe,
    // Port G pins
    input wire logic [2:1] port_g_pin_i,
    output logic [2:1] port_g_pin_o,
    output logic [2:1] port_g_pin_oe,
    output logic [2:1] port_g_pullup_on,
    // System
    input wire logic wake_event,
    output logic ext_reset_pin_level,
    output logic standby_active
);

    osgp_pkg::osgp_mode_t mode_reg;
    logic [2:0] port_f_data_latch_reg;
    logic [2:0] port_f_direction_reg;
    logic [2:0] port_f_open_drain_reg;
    logic [2:1] port_g_data_latch_reg;
    logic [2:1] port_g_direction_reg;
    logic [2:1] port_g_pullup_enable_reg;
    logic external_reset_select_reg;
    logic standby_pin_float_reg;
    logic read_modify_write_access_reg;

    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_lane0;
    logic wr_ok;
    logic rd_en;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic rd_ok;
    logic wr_take;
    logic hold;
    logic float_en;
    logic [2:0] f_avail;
    logic [2:0] f_in_level;
    logic [2:1] g_in_level;
    logic [2:0] f_read;
    logic [2:1] g_read;

    osgp_axil_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_lane0(wr_lane0),
        .wr_ok(wr_ok),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a == `OSGP_OFF_F_DATA) || (a == `OSGP_OFF_F_DIR) ||
            (a == `OSGP_OFF_G_DATA) || (a == `OSGP_OFF_G_DIR) ||
            (a == `OSGP_OFF_G_PULL) || (a == `OSGP_OFF_SYS_CFG) ||
            (a == `OSGP_OFF_STBY_CTRL) || (a == `OSGP_OFF_ACCESS);
    endfunction

    assign wr_ok = addr_mapped(wr_addr);
    assign rd_ok = addr_mapped(rd_addr);
    // Lane 0 alone carries every implemented bit
    assign wr_take = wr_en & wr_lane0;

    // Port registers; absent bits have no storage [RULE11] [RULE12] [RULE23]
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_f_data_latch_reg <= `OSGP_RST_F_DATA;
            port_f_direction_reg <= `OSGP_RST_F_DIR; // [RULE6]
            port_g_data_latch_reg <= `OSGP_RST_G_DATA;
            port_g_direction_reg <= `OSGP_RST_G_DIR; // [RULE18]
            port_g_pullup_enable_reg <= `OSGP_RST_G_PULL;
        end else if (wr_take) begin
            case (wr_addr)
                `OSGP_OFF_F_DATA: port_f_data_latch_reg <= wr_data[2:0]; // [RULE3]
                `OSGP_OFF_F_DIR: port_f_direction_reg <= wr_data[2:0];
                `OSGP_OFF_G_DATA: port_g_data_latch_reg <= wr_data[2:1]; // [RULE15]
                `OSGP_OFF_G_DIR: port_g_direction_reg <= wr_data[2:1];
                `OSGP_OFF_G_PULL: port_g_pullup_enable_reg <= wr_data[2:1]; // [RULE20]
                default: begin
                end
            endcase
        end
    end

    // System configuration and access mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            external_reset_select_reg <= 1'b0;
            port_f_open_drain_reg <= `OSGP_RST_F_OD;
            standby_pin_float_reg <= 1'b0;
            read_modify_write_access_reg <= 1'b0;
        end else if (wr_take) begin
            if (wr_addr == `OSGP_OFF_SYS_CFG) begin
                external_reset_select_reg <= wr_data[`OSGP_SYS_RSTSEL_BIT];
                port_f_open_drain_reg <= wr_data[`OSGP_SYS_OD_LSB +: 3];
            end
            if (wr_addr == `OSGP_OFF_STBY_CTRL) begin
                standby_pin_float_reg <= wr_data[`OSGP_STBY_FLOAT_BIT];
            end
            if (wr_addr == `OSGP_OFF_ACCESS) begin
                read_modify_write_access_reg <= wr_data[`OSGP_ACC_RMW_BIT];
            end
        end
    end

    // Standby mode; a wake in the same cycle as an entry lets the entry win
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= osgp_pkg::OSGP_RUN;
        end else begin
            case (mode_reg)
                osgp_pkg::OSGP_RUN: begin
                    if (wr_take && wr_addr == `OSGP_OFF_STBY_CTRL) begin
                        if (wr_data[`OSGP_STBY_STOP_BIT]) begin
                            mode_reg <= osgp_pkg::OSGP_STOP;
                        end else if (wr_data[`OSGP_STBY_WATCH_BIT]) begin
                            mode_reg <= osgp_pkg::OSGP_WATCH;
                        end
                    end
                end
                osgp_pkg::OSGP_STOP, osgp_pkg::OSGP_WATCH: begin
                    if (wake_event) begin
                        mode_reg <= osgp_pkg::OSGP_RUN;
                    end
                end
                default: mode_reg <= osgp_pkg::OSGP_RUN;
            endcase
        end
    end

    assign hold = (mode_reg != osgp_pkg::OSGP_RUN); // [RULE8]
    assign float_en = hold & standby_pin_float_reg; // [RULE7] [RULE19]
    assign standby_active = hold;
    // Pin 2 belongs to the reset input while selected [RULE10]
    assign f_avail = {~external_reset_select_reg, 2'b11};
    assign ext_reset_pin_level = external_reset_select_reg & port_f_pin_i[2];

    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_port_f
            osgp_pin_cell u_cell (
                .aclk(aclk),
                .aresetn(aresetn),
                .dir(port_f_direction_reg[i]), // [RULE1] [RULE2]
                .latch(port_f_data_latch_reg[i]),
                .open_drain(port_f_open_drain_reg[i]), // [RULE9]
                .avail(f_avail[i]),
                .hold(hold),
                .float_en(float_en),
                .pull_bit(1'b0),
                .pin_i(port_f_pin_i[i]),
                .pin_o(port_f_pin_o[i]),
                .pin_oe(port_f_pin_oe[i]),
                .pull_on(),
                .in_level(f_in_level[i])
            );
        end
        for (i = 1; i < 3; i = i + 1) begin : g_port_g
            osgp_pin_cell u_cell (
                .aclk(aclk),
                .aresetn(aresetn),
                .dir(port_g_direction_reg[i]), // [RULE13] [RULE14]
                .latch(port_g_data_latch_reg[i]),
                .open_drain(1'b0),
                .avail(1'b1),
                .hold(hold),
                .float_en(float_en),
                .pull_bit(port_g_pullup_enable_reg[i]), // [RULE20] [RULE21]
                .pin_i(port_g_pin_i[i]),
                .pin_o(port_g_pin_o[i]),
                .pin_oe(port_g_pin_oe[i]),
                .pull_on(port_g_pullup_on[i]),
                .in_level(g_in_level[i])
            );
        end
    endgenerate

    // Outputs and read-modify-write reads see the latch, inputs the pin
    assign f_read = (port_f_data_latch_reg & (port_f_direction_reg |
        {3{read_modify_write_access_reg}})) | (f_in_level & ~port_f_direction_reg &
        ~{3{read_modify_write_access_reg}}); // [RULE4] [RULE5]
    assign g_read = (port_g_data_latch_reg & (port_g_direction_reg |
        {2{read_modify_write_access_reg}})) | (g_in_level & ~port_g_direction_reg &
        ~{2{read_modify_write_access_reg}}); // [RULE16] [RULE17]

    always_comb begin
        rd_data = 8'h00; // [RULE23]
        case (rd_addr)
            `OSGP_OFF_F_DATA: rd_data = {5'h00, f_read};
            `OSGP_OFF_F_DIR: rd_data = {5'h00, port_f_direction_reg};
            `OSGP_OFF_G_DATA: rd_data = {5'h00, g_read, 1'b0};
            `OSGP_OFF_G_DIR: rd_data = {5'h00, port_g_direction_reg, 1'b0};
            `OSGP_OFF_G_PULL: rd_data = {5'h00, port_g_pullup_enable_reg, 1'b0};
            `OSGP_OFF_SYS_CFG: rd_data = {1'b0, port_f_open_drain_reg, 3'h0,
                external_reset_select_reg};
            `OSGP_OFF_STBY_CTRL: rd_data = {5'h00, mode_reg == osgp_pkg::OSGP_WATCH,
                mode_reg == osgp_pkg::OSGP_STOP, standby_pin_float_reg};
            `OSGP_OFF_ACCESS: rd_data = {7'h00, read_modify_write_access_reg};
            default: rd_data = 8'h00;
        endcase
    end

    sequence s_f_data_write;
        wr_take && wr_addr == `OSGP_OFF_F_DATA;
    endsequence

    sequence s_f_input_read;
        rd_en && rd_addr == `OSGP_OFF_F_DATA && !port_f_direction_reg[0] &&
            !read_modify_write_access_reg;
    endsequence

    property p_f_drive;
        @(posedge aclk) disable iff (!aresetn)
        !hold && port_f_direction_reg[1] && !port_f_open_drain_reg[1] |=>
            port_f_pin_oe[1] && port_f_pin_o[1] == $past(port_f_data_latch_reg[1]);
    endproperty
    a_f_drive: assert property (p_f_drive) else $error("port F output not driven"); // [RULE1]

    property p_input_off;
        @(posedge aclk) disable iff (!aresetn)
        !hold && !port_f_direction_reg[0] && !port_g_direction_reg[2] |=>
            !port_f_pin_oe[0] && !port_g_pin_oe[2];
    endproperty
    a_input_off: assert property (p_input_off) else $error("input pin driven"); // [RULE2]

    property p_f_latch_load;
        @(posedge aclk) disable iff (!aresetn)
        s_f_data_write |=> port_f_data_latch_reg == $past(wr_data[2:0]);
    endproperty
    a_f_latch_load: assert property (p_f_latch_load) else $error("latch not loaded"); // [RULE3]

    property p_f_pin_read;
        @(posedge aclk) disable iff (!aresetn)
        s_f_input_read |=> s_axi_rvalid && s_axi_rdata[0] == $past(f_in_level[0]);
    endproperty
    a_f_pin_read: assert property (p_f_pin_read) else $error("input read wrong"); // [RULE4]

    property p_f_latch_read;
        @(posedge aclk) disable iff (!aresetn)
        rd_en && rd_addr == `OSGP_OFF_F_DATA && port_f_direction_reg[1] |=>
            s_axi_rdata[1] == $past(port_f_data_latch_reg[1]);
    endproperty
    a_f_latch_read: assert property (p_f_latch_read) else $error("output read wrong"); // [RULE5]

    property p_reset_dir;
        @(posedge aclk) !aresetn |=> port_f_direction_reg == 3'h0 &&
            port_g_direction_reg == 2'h0 && port_f_pin_oe == 3'h0;
    endproperty
    a_reset_dir: assert property (p_reset_dir) else $error("direction not cleared"); // [RULE6]

    // Input gate follows the float flag at once, drivers one edge later
    property p_float;
        @(posedge aclk) disable iff (!aresetn)
        float_en |-> (f_in_level == 3'h0 && g_in_level == 2'h0) ##1
            (port_f_pin_oe == 3'h0 && port_g_pin_oe == 2'h0);
    endproperty
    a_float: assert property (p_float) else $error("pins not floated"); // [RULE7] [RULE19]

    property p_hold;
        @(posedge aclk) disable iff (!aresetn)
        hold && !standby_pin_float_reg ##1 hold |-> $stable(port_f_pin_oe) &&
            $stable(port_f_pin_o) && $stable(port_g_pin_oe);
    endproperty
    a_hold: assert property (p_hold) else $error("standby state not held"); // [RULE8]

    property p_open_drain;
        @(posedge aclk) disable iff (!aresetn)
        port_f_open_drain_reg[0] && port_f_data_latch_reg[0] |=> !port_f_pin_oe[0] ||
            $past(hold);
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain drove high"); // [RULE9]

    property p_reset_pin;
        @(posedge aclk) disable iff (!aresetn)
        external_reset_select_reg && !hold |=> !port_f_pin_oe[2];
    endproperty
    a_reset_pin: assert property (p_reset_pin) else $error("reset pin driven"); // [RULE10]

    property p_pull_low;
        @(posedge aclk) disable iff (!aresetn)
        port_g_pin_oe[1] && !port_g_pin_o[1] |-> !port_g_pullup_on[1];
    endproperty
    a_pull_low: assert property (p_pull_low) else $error("pull-up on low drive"); // [RULE21]

    property p_zero_upper;
        @(posedge aclk) disable iff (!aresetn)
        rd_en && rd_addr == `OSGP_OFF_G_DATA |=> s_axi_rdata[0] == 1'b0 &&
            s_axi_rdata[31:3] == 29'h0;
    endproperty
    a_zero_upper: assert property (p_zero_upper) else $error("absent bits nonzero"); // [RULE23]

endmodule

`default_nettype wire

/* File: bench/osgp_pins_model.sv */
// Board-side model of the port F and port G pins
`timescale 1ns/100ps
`default_nettype none

module osgp_pins_model (
    // Port F
    input wire logic [2:0] f_o,
    input wire logic [2:0] f_oe,
    input wire logic [2:0] f_ext,
    output logic [2:0] f_i,
    // Port G
    input wire logic [2:1] g_o,
    input wire logic [2:1] g_oe,
    input wire logic [2:1] g_ext,
    output logic [2:1] g_i
);
    // Board drives only pins the block has released
    assign f_i = (f_oe & f_o) | (~f_oe & f_ext);
    assign g_i = (g_oe & g_o) | (~g_oe & g_ext);
endmodule

`default_nettype wire

/* File: bench/oscillator_reset_shared_gpio_ports_tb.sv */
// Self-checking bench for the shared-pin GPIO block
`timescale 1ns/100ps
`default_nettype none
`include "osgp_consts.svh"

module oscillator_reset_shared_gpio_ports_tb;
    logic aclk = 0;
    logic aresetn, wake_event, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, ext_reset_pin_level, standby_active;
    logic [7:0] s_axi_awaddr, s_axi_araddr, r, m, dat, dir;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] port_f_pin_i, port_f_pin_o, port_f_pin_oe, f_ext;
    logic [2:1] port_g_pin_i, port_g_pin_o, port_g_pin_oe, port_g_pullup_on, g_ext;
    int fail_count = 0, checks = 0, cyc = 0;
    logic [33:0] exp_q[$];

    osgp_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_f_pin_i,
        .port_f_pin_o, .port_f_pin_oe, .port_g_pin_i, .port_g_pin_o, .port_g_pin_oe,
        .port_g_pullup_on, .wake_event, .ext_reset_pin_level, .standby_active);
    osgp_pins_model u_pins (.f_o(port_f_pin_o), .f_oe(port_f_pin_oe), .f_ext(f_ext),
        .f_i(port_f_pin_i), .g_o(port_g_pin_o), .g_oe(port_g_pin_oe), .g_ext(g_ext),
        .g_i(port_g_pin_i));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    function automatic logic [33:0] ok(input logic [7:0] d);
        return {26'h0, d};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
        logic ta, tw;
        ta = 0;
        tw = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge aclk);
            if (!ta && s_axi_awready) begin
                ta = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!tw && s_axi_wready) begin
                tw = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        chk("bresp", e, s_axi_bresp);
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
    endtask

    // Pin registers follow their control register one edge later
    task automatic pin(input bit p, input logic [7:0] eoe, input logic [7:0] eo);
        logic [7:0] oe, o;
        repeat (2) @(posedge aclk);
        oe = p ? {5'h0, port_g_pin_oe, 1'b0} : {5'h0, port_f_pin_oe};
        o = p ? {5'h0, port_g_pin_o, 1'b0} : {5'h0, port_f_pin_o};
        chk("pin_oe", eoe, oe);
        chk("pin_o", eo & eoe, o & oe);
    endtask

    always @(posedge aclk) begin
        if (aresetn && s_axi_rvalid && s_axi_rready) begin
            chk("rdata", exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
        end
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end

    initial forever #5 aclk = ~aclk;

    initial begin
        {aresetn, wake_event, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, f_ext, g_ext} = '0;
        s_axi_wstrb = 4'hF;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        void'($urandom(32'hCE38));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int p = 0; p < 2; p++) begin
            dat = p ? `OSGP_OFF_G_DATA : `OSGP_OFF_F_DATA;
            dir = p ? `OSGP_OFF_G_DIR : `OSGP_OFF_F_DIR;
            m = p ? 8'h06 : 8'h07;
            r = 8'($urandom);
            rd(dir, ok(8'h00));
            pin(p, 8'h00, 8'h00);
            wr(dir, 8'hFF, `OSGP_RESP_OKAY);
            rd(dir, ok(m));
            wr(dat, r, `OSGP_RESP_OKAY);
            pin(p, m, r);
            f_ext <= ~r[2:0];
            g_ext <= ~r[2:1];
            rd(dat, ok(r & m));
            wr(dir, 8'h00, `OSGP_RESP_OKAY);
            pin(p, 8'h00, 8'h00);
            rd(dat, ok(~r & m));
            wr(`OSGP_OFF_ACCESS, 8'h01, `OSGP_RESP_OKAY);
            rd(dat, ok(r & m));
            wr(`OSGP_OFF_ACCESS, 8'h00, `OSGP_RESP_OKAY);
            $display("test port %0d done", p);
        end
        wr(8'h20, 8'h01, `OSGP_RESP_SLVERR);
        s_axi_wstrb <= 4'hE;
        wr(`OSGP_OFF_F_DIR, 8'h05, `OSGP_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd(`OSGP_OFF_F_DIR, ok(8'h00));
        wr(`OSGP_OFF_G_PULL, 8'hFF, `OSGP_RESP_OKAY);
        pin(1, 8'h00, 8'h00);
        chk("pullup", 2'b11, port_g_pullup_on);
        wr(`OSGP_OFF_G_DATA, 8'h00, `OSGP_RESP_OKAY);
        wr(`OSGP_OFF_G_DIR, 8'h06, `OSGP_RESP_OKAY);
        pin(1, 8'h06, 8'h00);
        chk("pullup", 2'b00, port_g_pullup_on);
        wr(`OSGP_OFF_F_DIR, 8'h07, `OSGP_RESP_OKAY);
        wr(`OSGP_OFF_F_DATA, 8'h07, `OSGP_RESP_OKAY);
        wr(`OSGP_OFF_SYS_CFG, 8'h11, `OSGP_RESP_OKAY);
        pin(0, 8'h02, 8'h02);
        chk("rst_level", f_ext[2], ext_reset_pin_level);
        wr(`OSGP_OFF_SYS_CFG, 8'h00, `OSGP_RESP_OKAY); // Pin 2 back to port use
        $display("test pull-up and shared pins done");
        wr(`OSGP_OFF_STBY_CTRL, 8'h02, `OSGP_RESP_OKAY);
        wr(`OSGP_OFF_F_DATA, 8'h00, `OSGP_RESP_OKAY);
        pin(0, 8'h07, 8'h07);
        chk("standby", 1'b1, standby_active);
        wake_event <= 1'b1;
        @(posedge aclk);
        wake_event <= 1'b0;
        pin(0, 8'h07, 8'h00);
        f_ext <= 3'h7;
        g_ext <= 2'h3;
        wr(`OSGP_OFF_F_DIR, 8'h00, `OSGP_RESP_OKAY);
        wr(`OSGP_OFF_STBY_CTRL, 8'h05, `OSGP_RESP_OKAY);
        pin(0, 8'h00, 8'h00);
        pin(1, 8'h00, 8'h00);
        rd(`OSGP_OFF_F_DATA, ok(8'h00));
        rd(`OSGP_OFF_STBY_CTRL, ok(8'h05));
        $display("test standby done");
        end_sim();
    end
endmodule

`default_nettype wire
